/* File: hdl/hcc_pkg.sv */
// constants and types of the hysteresis chopper timing block
package hcc_pkg;
  // ==========================================================
  // timing figures in system clock cycles
  localparam int unsigned SLOW_BASE_CLKS  = 24;   // slow decay base
  localparam int unsigned SLOW_STEP_CLKS  = 32;   // per off-time code
  localparam int unsigned DEC_PERIOD_CLKS = 16;   // clocks per decrement
  localparam logic [5:0]  BLANK_CLKS_0    = 6'd16;
  localparam logic [5:0]  BLANK_CLKS_1    = 6'd24;
  localparam logic [5:0]  BLANK_CLKS_2    = 6'd36;
  localparam logic [5:0]  BLANK_CLKS_3    = 6'd54;
  localparam int signed   END_CODE_BIAS   = 3;    // end value = code - 3
  // ==========================================================
  // field widths and reset values
  localparam int unsigned OFF_TIME_W   = 4;
  localparam int unsigned HYST_START_W = 3;
  localparam int unsigned HYST_END_W   = 4;
  localparam int unsigned BLANK_SEL_W  = 2;
  localparam int unsigned HYST_W  = 6;            // signed hysteresis
  localparam int unsigned CNT_W   = 9;            // up to 24+32*15 = 504
  localparam logic [CNT_W-1:0] CNT_RST = 9'h000;
  localparam logic [3:0]  DIV_RST = 4'h0;
  localparam logic signed [HYST_W-1:0] HYST_RST = 6'sh00;
  localparam logic [5:0]  BLANK_RST = 6'h00;

  typedef enum logic [2:0] {
    HCC_OFF, HCC_ON, HCC_SLOW1, HCC_FAST, HCC_SLOW2
  } hcc_phase_t;

  typedef struct packed {
    hcc_phase_t                 phase;
    logic [CNT_W-1:0]           cnt;       // slow decay timer
    logic [5:0]                 blank;     // blanking timer
    logic [3:0]                 div;       // decrement prescaler
    logic signed [HYST_W-1:0]   hyst;      // active hysteresis
    logic signed [HYST_W-1:0]   hyst_end;  // latched end value
    logic [CNT_W-1:0]           slow_len;  // latched slow length
    logic [5:0]                 blank_len; // latched blank length
    logic                       on_drv;
    logic                       fast_drv;
    logic                       slow_drv;
    logic                       cyc_start;
  } hcc_state_t;
endpackage : hcc_pkg

/* File: hdl/hcc_chopper.sv */
// one-coil hysteresis chopper phase sequencer with blanking and decrementer
`timescale 1ns/1ps
module hcc_chopper
  import hcc_pkg::*;
(
  input  wire logic               MCLK,
  input  wire logic               RST,
  input  wire logic [OFF_TIME_W-1:0]   OFF_TIME_SETTING,
  input  wire logic [HYST_START_W-1:0] HYSTERESIS_START_OFFSET,
  input  wire logic [HYST_END_W-1:0]   HYSTERESIS_END_VALUE,
  input  wire logic [BLANK_SEL_W-1:0]  BLANK_TIME_SELECT,
  input  wire logic               CHOPPER_MODE,     // 0 = hysteresis chopper
  input  wire logic               CMP_ABOVE_TARGET, // current >= target
  input  wire logic               CMP_BELOW_HYST,   // current < target - hyst
  output logic                    BRIDGE_ON,
  output logic                    BRIDGE_FAST,
  output logic                    BRIDGE_SLOW,
  output logic                    CYCLE_START,
  output logic signed [HYST_W-1:0] HYST_ACTIVE
);
  // ==========================================================
  // state
  hcc_state_t s_q;
  hcc_state_t s_d;
  logic       enable;
  logic       blank_done;
  logic [5:0] blank_sel;
  logic [CNT_W-1:0]         slow_sel;
  logic signed [HYST_W-1:0] hyst_end_sel;
  logic signed [HYST_W-1:0] hstart_sel;

  // zero off time disables the chopper
  assign enable = (OFF_TIME_SETTING != '0) && !CHOPPER_MODE;

  always_comb begin
    case (BLANK_TIME_SELECT)
      2'd0:    blank_sel = BLANK_CLKS_0;
      2'd1:    blank_sel = BLANK_CLKS_1;
      2'd2:    blank_sel = BLANK_CLKS_2;
      default: blank_sel = BLANK_CLKS_3;
    endcase
  end

  // slow decay length from off time
  assign slow_sel = CNT_W'(SLOW_BASE_CLKS + SLOW_STEP_CLKS * OFF_TIME_SETTING);
  // end value is code minus three
  assign hyst_end_sel = $signed({2'b00, HYSTERESIS_END_VALUE}) - HYST_W'(END_CODE_BIAS);
  // start offset is code plus one on top of end
  assign hstart_sel = hyst_end_sel + $signed({3'b000, HYSTERESIS_START_OFFSET}) + 6'sd1;

  // comparator only counts once blanking has run out
  assign blank_done = (s_q.blank == '0);

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.cyc_start = 1'b0;
    if (s_q.blank != '0) begin
      s_d.blank = s_q.blank - 6'd1;
    end
    // decrement prescaler, every 16 clocks in a cycle
    if (s_q.phase != HCC_OFF) begin
      s_d.div = s_q.div + 4'd1;
      if (s_q.div == 4'(DEC_PERIOD_CLKS - 1) && s_q.hyst > s_q.hyst_end) begin
        s_d.hyst = s_q.hyst - 6'sd1;
      end
    end
    case (s_q.phase)
      HCC_OFF: begin
        if (enable) begin
          s_d.phase = HCC_ON;
          s_d.cyc_start = 1'b1;
          s_d.slow_len  = slow_sel;
          s_d.blank_len = blank_sel;
          s_d.hyst_end  = hyst_end_sel;
          s_d.hyst      = hstart_sel;
          s_d.div       = DIV_RST;
          s_d.blank     = blank_sel - 6'd1;
        end
      end
      HCC_ON: begin
        // on ends at target after blanking
        if (blank_done && CMP_ABOVE_TARGET) begin
          // on is followed by first slow decay
          s_d.phase = HCC_SLOW1;
          s_d.cnt   = s_q.slow_len - 9'd1;
        end
      end
      HCC_SLOW1: begin
        if (s_q.cnt == '0) begin
          s_d.phase = HCC_FAST;
          s_d.blank = s_q.blank_len - 6'd1;
        end else begin
          s_d.cnt = s_q.cnt - 9'd1;
        end
      end
      HCC_FAST: begin
        // fast ends below target by hysteresis
        if (blank_done && CMP_BELOW_HYST) begin
          s_d.phase = HCC_SLOW2;
          s_d.cnt   = s_q.slow_len - 9'd1;
        end
      end
      HCC_SLOW2: begin
        if (s_q.cnt == '0) begin
          s_d.phase = HCC_OFF;
        end else begin
          s_d.cnt = s_q.cnt - 9'd1;
        end
      end
      default: s_d.phase = HCC_OFF;
    endcase
    // off time zero or other mode: free-wheel at once
    if (!enable) begin
      s_d.phase = HCC_OFF;
    end
    s_d.on_drv   = (s_d.phase == HCC_ON);
    s_d.fast_drv = (s_d.phase == HCC_FAST);
    s_d.slow_drv = (s_d.phase == HCC_SLOW1) || (s_d.phase == HCC_SLOW2);
  end

  // ==========================================================
  // state register; off state between cycles costs one clock
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      s_q <= '{phase: HCC_OFF, cnt: CNT_RST, blank: BLANK_RST, div: DIV_RST,
               hyst: HYST_RST, hyst_end: HYST_RST, slow_len: CNT_RST,
               blank_len: BLANK_RST, on_drv: 1'b0, fast_drv: 1'b0,
               slow_drv: 1'b0, cyc_start: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign BRIDGE_ON   = s_q.on_drv;
  assign BRIDGE_FAST = s_q.fast_drv;
  assign BRIDGE_SLOW = s_q.slow_drv;
  assign CYCLE_START = s_q.cyc_start;
  assign HYST_ACTIVE = s_q.hyst;

  // ==========================================================
  // assertions
  // slow timer load
  a_slow_length: assert property (@(posedge MCLK) disable iff (RST)
    $rose(s_q.phase == HCC_SLOW1) |-> (s_q.phase == HCC_SLOW1) [*1] ##0
      (s_q.cnt == s_q.slow_len - 9'd1))
    else $error("slow decay timer not loaded with slow length");
  a_order_slow1: assert property (@(posedge MCLK) disable iff (RST)
    (s_q.phase == HCC_FAST) |-> $past(s_q.phase) inside {HCC_SLOW1, HCC_FAST})
    else $error("fast decay not preceded by first slow decay");
  a_order_slow2: assert property (@(posedge MCLK) disable iff (RST)
    (s_q.phase == HCC_SLOW2) |-> $past(s_q.phase) inside {HCC_FAST, HCC_SLOW2})
    else $error("second slow decay not preceded by fast decay");
  a_start_pulse: assert property (@(posedge MCLK) disable iff (RST)
    s_q.cyc_start |-> (s_q.phase == HCC_ON && $past(s_q.phase) == HCC_OFF))
    else $error("cycle start pulse outside first on clock");
  // on held while blanking; only a disable may cut it
  a_blank_mask: assert property (@(posedge MCLK) disable iff (RST)
    (s_q.phase == HCC_ON && s_q.blank != '0) |=> (s_q.phase == HCC_ON || !$past(enable)))
    else $error("on phase ended during blanking");
  a_fast_mask: assert property (@(posedge MCLK) disable iff (RST)
    (s_q.phase == HCC_FAST && s_q.blank != '0) |=> (s_q.phase == HCC_FAST || !$past(enable)))
    else $error("fast decay ended during blanking");
  a_blank_fast: assert property (@(posedge MCLK) disable iff (RST)
    $rose(s_q.phase == HCC_FAST) |-> (s_q.blank == s_q.blank_len - 6'd1))
    else $error("fast decay not blanked");
  a_hyst_floor: assert property (@(posedge MCLK) disable iff (RST)
    (s_q.phase != HCC_OFF) |-> (s_q.hyst >= s_q.hyst_end))
    else $error("hysteresis below end value");
  a_hyst_step: assert property (@(posedge MCLK) disable iff (RST)
    (s_q.phase != HCC_OFF && $past(s_q.phase) != HCC_OFF && s_q.hyst != $past(s_q.hyst))
      |-> ($past(s_q.div) == 4'hf && s_q.hyst == $past(s_q.hyst) - 6'sd1))
    else $error("hysteresis stepped off the 16 clock grid");
  a_freewheel: assert property (@(posedge MCLK) disable iff (RST)
    (OFF_TIME_SETTING == '0) |=> !BRIDGE_ON && !BRIDGE_FAST && !BRIDGE_SLOW)
    else $error("bridge driven with zero off time");
  a_load_start: assert property (@(posedge MCLK) disable iff (RST)
    (s_q.phase == HCC_OFF && enable) |=> (s_q.hyst == $past(hstart_sel)
      && s_q.slow_len == $past(slow_sel)))
    else $error("cycle start did not latch fields");

  // main scenarios, including a cycle cut short by a disable
  c_full_cycle: cover property (@(posedge MCLK) disable iff (RST)
    s_q.phase == HCC_SLOW2 ##1 s_q.phase == HCC_OFF);
  c_hyst_reaches_end: cover property (@(posedge MCLK) disable iff (RST)
    s_q.phase == HCC_FAST && s_q.hyst == s_q.hyst_end);
  c_fast_ended: cover property (@(posedge MCLK) disable iff (RST)
    s_q.phase == HCC_FAST ##1 s_q.phase == HCC_SLOW2);
  c_forced_idle: cover property (@(posedge MCLK) disable iff (RST)
    s_q.phase == HCC_FAST ##1 s_q.phase == HCC_OFF);
  c_long_blank: cover property (@(posedge MCLK) disable iff (RST)
    s_q.cyc_start && s_q.blank_len == BLANK_CLKS_3);
endmodule // hcc_chopper

/* File: test/hcc_coil_model.sv */
// coil and current comparator model for the chopper bench
`timescale 1ns/1ps
module hcc_coil_model
  import hcc_pkg::*;
(
  input  wire logic                     MCLK,
  input  wire logic                     BRIDGE_ON,
  input  wire logic                     BRIDGE_FAST,
  input  wire logic signed [HYST_W-1:0] HYST_ACTIVE,
  input  wire logic [31:0]              rise,
  output logic                          cmp_above,
  output logic                          cmp_below
);
  int cur = 0;
  // ==========================================================
  // coil: ramps while driven, falls in fast decay, holds in slow
  always @(posedge MCLK) begin
    #1;
    if (BRIDGE_ON) cur = cur + int'(rise);
    if (BRIDGE_FAST) cur = cur - 3;
  end
  // comparators see no blanking; the block must mask them itself
  assign cmp_above = cur >= 100;
  assign cmp_below = cur < 100 - int'(HYST_ACTIVE);
endmodule // hcc_coil_model

/* File: test/testbench.sv */
// self-checking bench for the hysteresis chopper timing block
`timescale 1ns/1ps
module testbench;
  import hcc_pkg::*;
  logic MCLK = 0, RST = 1, mode = 0, above, below, on, fast, slow, cs;
  logic [3:0] off_time = 4'h1, hyst_end = 4'h3, tp, hp;
  logic [2:0] hyst_start = 3'h0, sp, pc, c;
  logic [1:0] blank_sel = 2'h0, bp2;
  logic signed [5:0] hyst;
  logic [2:0] seq [5] = '{3'b100, 3'b001, 3'b010, 3'b001, 3'b000};
  int blk [4] = '{16, 24, 36, 54};
  int rise = 2, num_errors = 0, total_checks = 0;
  int st, ln, k, eh, he, sl, bl, ncyc, i, j;
  bit fp, ap, bp;
  always #2 MCLK = ~MCLK;
  hcc_chopper i_hcc_chopper (.MCLK(MCLK), .RST(RST), .OFF_TIME_SETTING(off_time),
    .HYSTERESIS_START_OFFSET(hyst_start), .HYSTERESIS_END_VALUE(hyst_end),
    .BLANK_TIME_SELECT(blank_sel), .CHOPPER_MODE(mode), .CMP_ABOVE_TARGET(above),
    .CMP_BELOW_HYST(below), .BRIDGE_ON(on), .BRIDGE_FAST(fast),
    .BRIDGE_SLOW(slow), .CYCLE_START(cs), .HYST_ACTIVE(hyst));
  hcc_coil_model i_hcc_coil_model (.MCLK(MCLK), .BRIDGE_ON(on), .BRIDGE_FAST(fast),
    .HYST_ACTIVE(hyst), .rise(rise), .cmp_above(above), .cmp_below(below));
  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      num_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // reference model; fields seen one edge back, as the block latched them
  always @(posedge MCLK) begin
    c = {on, fast, slow};
    if (RST) begin
      st = 4;
      pc = 3'b000;
      ln = 0;
    end else begin
      if (c !== pc) begin
        if (fp) chk(c === seq[(st + 1) % 5], "phase order");
        if (fp && pc == 3'b001) chk(ln == sl, "slow length");
        if (fp && (pc[2] || pc[1])) chk(ln >= bl, "blank early");
        if (fp && pc[2]) chk(ap, "on end");
        if (fp && pc[1]) chk(bp, "fast end");
        st = fp ? (st + 1) % 5 : 4;
        ln = 0;
      end else if (fp && ln >= bl && (c[2] || c[1])) begin
        // blanking over and comparator seen: the phase must have ended
        chk(!(c[2] && ap) && !(c[1] && bp), "late phase end");
      end
      // start pulse only on the first clock of each on phase
      chk(cs === (c === 3'b100 && pc === 3'b000), "cycle start");
      ln++;
      if (cs === 1'b1) begin
        ncyc++;
        he = int'(hp) - 3;
        eh = he + int'(sp) + 1;
        k = 0;
        sl = 24 + 32 * int'(tp);
        bl = blk[bp2];
      end else if (c !== 3'b000) begin
        k++;
        if (k % 16 == 0 && eh > he) eh--;
      end
      if (c !== 3'b000) chk(hyst === 6'(eh), "hysteresis");
    end
    pc = c;
    ap = above;
    bp = below;
    fp = off_time != 0 && !mode;
    tp = off_time;
    hp = hyst_end;
    sp = hyst_start;
    bp2 = blank_sel;
  end
  // ==========================================================
  // stimulus: random legal fields, changed mid-cycle, then forced idle
  initial begin
    void'($urandom(32'h6a2d_8a8e));
    repeat (5) @(posedge MCLK);
    #1 RST = 0;
    for (i = 0; i < 8; i++) begin
      ncyc = 0;
      for (j = 0; j < 3; j++) begin
        @(posedge MCLK);
        #1;
        // sum kept at most 15, short off time
        off_time = 4'(1 + $urandom % 3);
        blank_sel = 2'(i + j);
        hyst_start = 3'($urandom);
        hyst_end = 4'($urandom % (16 - hyst_start));
        rise = 1 + $urandom % 3;
        repeat (200 + $urandom % 300) @(posedge MCLK);
      end
      chk(ncyc > 0, "no cycles");
      @(posedge MCLK);
      #1;
      if (i % 2) mode = 1;
      else off_time = 4'h0;
      repeat (3) @(posedge MCLK);
      repeat (20) @(posedge MCLK) chk({on, fast, slow} === 3'b000, "not idle");
      #1 mode = 0;
      $display("test %0d done", i);
    end
    test_done();
  end
endmodule // testbench
